// file: bench/prs_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module prs_core_model
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic halt_i,
  output var logic instr_valid_o,
  output var logic [7:0] instr_opcode_o
);
  logic pend_reg = 1'b0;
  // A no-operation always leads, so sleep never lands mid-instruction
  always @(posedge clk_i)
  begin
    instr_valid_o <= go_i || pend_reg;
    pend_reg <= go_i;
    instr_opcode_o <= go_i ? prs_pkg::OPC_NOP : halt_i ? prs_pkg::OPC_HALT : prs_pkg::OPC_STOP;
  end
endmodule : prs_core_model
`default_nettype wire

// file: bench/prs_power_reset_sleep_test.sv
`timescale 1ns/1ns
`default_nettype none
module prs_power_reset_sleep_test;
  logic clk_i = 1'b0, reset_n_i = 1'b0, power_ok_i = 1'b0, ext_reset_i = 1'b0, usb_reset_i = 1'b0;
  logic irq_any_i = 1'b0, halt_sel = 1'b0, wdog_halt_data_i = 1'b1, instr_valid_i;
  logic [4:0] pls = 5'h00;
  logic [6:0] port2_i = 7'h00;
  logic [3:0] port3_i = 4'h0;
  logic [7:0] instr_opcode_i;
  logic core_reset_n_o, core_clk_en_o, osc_enable_o, timer_irq_en_o, resume_load_o, warm_start_flag_o;
  logic wdog_halt_en_o, wdog_running_o;
  logic [15:0] resume_addr_o;
  wire go = pls[0];
  wire wdog_enable_i = pls[1];
  wire wdog_refresh_i = pls[2];
  wire wdog_halt_wr_i = pls[3];
  wire flag_access_i = pls[4];
  int errors = 0, n_compared = 0, cyc = 0, cnt;
  logic [19:0] rows [4] = '{20'h1_000C, 20'h2_000C, 20'h4_000C, 20'h8_000C};
  always #2 clk_i = ~clk_i;
  prs_core_model CORE (.clk_i, .go_i(go), .halt_i(halt_sel), .instr_valid_o(instr_valid_i),
    .instr_opcode_o(instr_opcode_i));
  prs_power_reset_sleep #(.WDOG_PERIOD(50)) DUT (.clk_i, .reset_n_i, .power_ok_i, .ext_reset_i, .usb_reset_i,
    .port2_i, .port3_i, .irq_any_i, .instr_valid_i, .instr_opcode_i, .wdog_enable_i, .wdog_refresh_i,
    .wdog_halt_wr_i, .wdog_halt_data_i, .flag_access_i, .core_reset_n_o, .core_clk_en_o, .osc_enable_o,
    .timer_irq_en_o, .resume_load_o, .resume_addr_o, .warm_start_flag_o, .wdog_halt_en_o, .wdog_running_o);
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({15'h0000, got}, {15'h0000, exp});
  endtask : cmp_bit
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic pulse(input int k);
    @(posedge clk_i) pls[k] <= 1'b1;
    @(posedge clk_i) pls <= 5'h00;
  endtask : pulse
  task automatic wait_for(ref logic s, input int lim);
    cnt = 0;
    do
    begin
      tick(1);
      cnt++;
    end
    while (s !== 1'b1 && cnt < lim);
  endtask : wait_for
  task automatic results;
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // Bounds a hang; the whole run needs under 3000 cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      errors++;
      results();
    end
  end
  initial
  begin
    tick(3);
    reset_n_i <= 1'b1;
    tick(1);
    cmp_bit(warm_start_flag_o, 1'b0);
    cmp_bit(wdog_halt_en_o, 1'b1);
    cmp_bit(wdog_running_o, 1'b0);
    power_ok_i <= 1'b1;
    wait_for(core_reset_n_o, 2000);
    cmp_bit(cnt >= 1026 && cnt <= 1029, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      halt_sel <= 1'b0;
      pulse(0);
      tick(6);
      cmp_bit(osc_enable_o | core_clk_en_o | timer_irq_en_o, 1'b0);
      ext_reset_i <= rows[i][16];
      usb_reset_i <= rows[i][17];
      port2_i <= port2_i ^ {7{rows[i][18]}};
      port3_i <= port3_i ^ {4{rows[i][19]}};
      wait_for(resume_load_o, 8);
      cmp_bit(resume_load_o, 1'b1);
      cmp_word(resume_addr_o, rows[i][15:0]);
      ext_reset_i <= 1'b0;
      usb_reset_i <= 1'b0;
      tick(3);
      cmp_bit(core_clk_en_o & core_reset_n_o, 1'b1);
    end
    halt_sel <= 1'b1;
    pulse(0);
    tick(6);
    cmp_bit(core_clk_en_o, 1'b0);
    cmp_bit(timer_irq_en_o & osc_enable_o, 1'b1);
    irq_any_i <= 1'b1;
    tick(3);
    cmp_bit(core_clk_en_o, 1'b1);
    irq_any_i <= 1'b0;
    wdog_halt_data_i <= 1'b0;
    pulse(3);
    tick(1);
    cmp_bit(wdog_halt_en_o, 1'b0);
    pulse(1);
    repeat (4)
    begin
      tick(35);
      pulse(2);
    end
    cmp_bit(warm_start_flag_o, 1'b0);
    cmp_bit(wdog_running_o, 1'b1);
    pulse(0);
    tick(80);
    cmp_bit(warm_start_flag_o | core_clk_en_o, 1'b0);
    irq_any_i <= 1'b1;
    tick(3);
    irq_any_i <= 1'b0;
    pulse(2);
    wait_for(warm_start_flag_o, 100);
    cmp_bit(cnt >= 45 && cnt <= 55, 1'b1);
    pulse(4);
    tick(1);
    cmp_bit(warm_start_flag_o, 1'b0);
    reset_n_i <= 1'b0;
    tick(2);
    reset_n_i <= 1'b1;
    tick(1);
    cmp_bit(warm_start_flag_o | wdog_running_o | core_reset_n_o, 1'b0);
    cmp_bit(wdog_halt_en_o, 1'b1);
    wait_for(core_reset_n_o, 2000);
    cmp_bit(cnt >= 1026 && cnt <= 1029, 1'b1);
    results();
  end
endmodule : prs_power_reset_sleep_test
bind prs_power_reset_sleep prs_props u_props (.clk_i, .reset_n_i, .power_ok_i, .ext_reset_i, .usb_reset_i,
  .port2_i, .port3_i, .irq_any_i, .instr_valid_i, .instr_opcode_i, .core_reset_n_o, .core_clk_en_o,
  .osc_enable_o, .resume_load_o, .resume_addr_o, .warm_start_flag_o, .wdog_halt_en_o);
`default_nettype wire

// file: bench/prs_props.sv
`timescale 1ns/1ns
`default_nettype none
module prs_props
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic power_ok_i,
  input wire logic ext_reset_i,
  input wire logic usb_reset_i,
  input wire logic [6:0] port2_i,
  input wire logic [3:0] port3_i,
  input wire logic irq_any_i,
  input wire logic instr_valid_i,
  input wire logic [7:0] instr_opcode_i,
  input wire logic core_reset_n_o,
  input wire logic core_clk_en_o,
  input wire logic osc_enable_o,
  input wire logic resume_load_o,
  input wire logic [15:0] resume_addr_o,
  input wire logic warm_start_flag_o,
  input wire logic wdog_halt_en_o
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  logic [11:0] low_reg;
  logic halted;
  assign halted = core_reset_n_o && osc_enable_o && !core_clk_en_o;
  // Counts only power-good low time, so cycles spent with power failed never count toward the delay length
  always_ff @(posedge clk_i)
    low_reg <= (core_reset_n_o || !power_ok_i) ? 12'h000 : low_reg + 12'h001;
  chk_por_length: assert property ($rose(core_reset_n_o) && !warm_start_flag_o |->
    low_reg inside {[12'h401:12'h404]}) else $error("delay length wrong");
  chk_stop_enter: assert property (instr_valid_i && instr_opcode_i == prs_pkg::OPC_STOP
    && core_reset_n_o && core_clk_en_o |-> ##[1:2] !osc_enable_o && !core_clk_en_o) else $error("no stop");
  chk_halt_wake: assert property (halted && irq_any_i |-> ##[1:2] core_clk_en_o)
    else $error("halt not left");
  chk_stop_wake: assert property (!osc_enable_o && !resume_load_o && (ext_reset_i || usb_reset_i || $changed(port2_i)
    || $changed(port3_i)) |=> resume_load_o) else $error("stop not left");
  chk_resume_addr: assert property (resume_load_o |->
    resume_addr_o == prs_pkg::STOP_RESUME_ADDR ##1 !resume_load_o) else $error("bad resume");
  chk_skip_delay: assert property (resume_load_o |=> core_clk_en_o && core_reset_n_o)
    else $error("delay not skipped");
  chk_wdog_reset: assert property ($rose(warm_start_flag_o) |-> !core_reset_n_o ##1 core_reset_n_o)
    else $error("bad watchdog reset");
  chk_reset_vals: assert property ($rose(reset_n_i) |-> wdog_halt_en_o && !warm_start_flag_o)
    else $error("bad reset values");
endmodule : prs_props
`default_nettype wire

// file: core/prs_pkg.sv
package prs_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 250_000_000;
  localparam int unsigned POR_CYCLES = 1024;
  localparam int unsigned WDOG_TIMEOUT_MS = 50;
  localparam int unsigned WDOG_CYCLES = (CLK_FREQ_HZ / 1000) * WDOG_TIMEOUT_MS;
  localparam int unsigned WDOG_W = 24;
  localparam int unsigned POR_W = 11;
  // ----------------------------------------
  // Core interface constants
  // ----------------------------------------
  localparam logic [7:0] OPC_NOP = 8'hFF;
  localparam logic [7:0] OPC_STOP = 8'h6F;
  localparam logic [7:0] OPC_HALT = 8'h7F;
  localparam logic [15:0] STOP_RESUME_ADDR = 16'h000C;
  localparam int unsigned WARM_BIT_POS = 7;
  localparam int unsigned WDOG_HALT_BIT_POS = 5;
  localparam logic WDOG_HALT_RESET = 1'b1;
  localparam int unsigned WAKE_W = 11;
endpackage : prs_pkg

// file: core/prs_por_timer.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// One-shot cycle counter
// ----------------------------------------
module prs_por_timer
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  output logic busy_o
);
  logic [prs_pkg::POR_W-1:0] count_reg;
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      count_reg <= '0;
      busy_o <= 1'b0;
    end
    else if (start_i)
    begin
      count_reg <= prs_pkg::POR_W'(prs_pkg::POR_CYCLES - 1);
      busy_o <= 1'b1;
    end
    else if (count_reg != '0)
      count_reg <= count_reg - 1'b1;
    else
      busy_o <= 1'b0;
  end
endmodule : prs_por_timer
`default_nettype wire

// file: core/prs_power_reset_sleep.sv
// How it works
// RL1 - After power-up, core held off for 1024 clock cycles.
// RL2 - Delay is a one-shot, started by power-fail to power-OK transition.
// RL3 - Waking from oscillator-stopped sleep skips the power-on delay.
// RL4 - Watchdog counts system clocks, timeout about 50 ms.
// RL5 - Build-time option makes watchdog run from power-on automatically.
// RL6 - Flag reads 0 after cold start, 1 after watchdog reset.
// RL7 - Start-type flag is read-only; any access clears it.
// RL8 - Control bit, reset 1, keeps watchdog counting in clock-gated sleep.
// RL9 - Clock-gated sleep stops core clock; timer and ext requests 0-3 run.
// RL10 - Any interrupt ends clock-gated sleep.
// RL11 - Oscillator-stopped sleep stops internal clock and oscillator.
// RL12 - Stop sleep ends on ext reset, USB reset, port 2 or port 3 activity.
// RL13 - Leaving stop sleep restarts execution at address 000C.
// RL14 - Core issues a no-operation before each sleep instruction.
// RL15 - Watchdog timeout resets the core and sets the start-type flag.
// RL16 - Software refresh reloads the watchdog with its full period.
`timescale 1ns/1ns
`default_nettype none
module prs_power_reset_sleep
#(
  parameter logic WDOG_AUTO_START = 1'b0,
  parameter int unsigned WDOG_PERIOD = prs_pkg::WDOG_CYCLES
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic power_ok_i,
  input wire logic ext_reset_i,
  input wire logic usb_reset_i,
  input wire logic [6:0] port2_i,
  input wire logic [3:0] port3_i,
  input wire logic irq_any_i,
  input wire logic instr_valid_i,
  input wire logic [7:0] instr_opcode_i,
  input wire logic wdog_enable_i,
  input wire logic wdog_refresh_i,
  input wire logic wdog_halt_wr_i,
  input wire logic wdog_halt_data_i,
  input wire logic flag_access_i,
  output logic core_reset_n_o,
  output logic core_clk_en_o,
  output logic osc_enable_o,
  output logic timer_irq_en_o,
  output logic resume_load_o,
  output logic [15:0] resume_addr_o,
  output logic warm_start_flag_o,
  output logic wdog_halt_en_o,
  output logic wdog_running_o
);
  // ----------------------------------------
  // Sleep state
  // ----------------------------------------
  typedef enum logic [2:0] {
    PRS_RUN = 3'b001,
    PRS_HALT = 3'b010,
    PRS_STOP = 3'b100
  } prs_state_t;
  prs_state_t state_reg;
  logic power_ok_reg;
  logic por_start;
  logic por_busy;
  logic [prs_pkg::WAKE_W-1:0] wake_prev_reg;
  logic stop_wake;
  logic stop_exit;
  logic core_hold;
  logic [prs_pkg::WDOG_W-1:0] wdog_count_reg;
  logic wdog_fire;
  logic wdog_tick;
  // ----------------------------------------
  // Power-on delay
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      power_ok_reg <= 1'b0;
    else
      power_ok_reg <= power_ok_i;
  end
  assign por_start = power_ok_i && !power_ok_reg; // RL2
  prs_por_timer u_por
  (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .start_i(por_start),
    .busy_o(por_busy)
  );
  // ----------------------------------------
  // Stop wake detection
  // ----------------------------------------
  // Port activity means any edge, since pins idle at either level
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      wake_prev_reg <= '0;
    else
      wake_prev_reg <= {port2_i, port3_i};
  end
  assign stop_wake = ext_reset_i || usb_reset_i || (wake_prev_reg != {port2_i, port3_i}); // RL12
  // ----------------------------------------
  // Sleep sequencing
  // ----------------------------------------
  // Sleep opcodes without a preceding no-op are still honoured; flushing is the core's job
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i || wdog_fire)
      state_reg <= PRS_RUN;
    else
    begin
      case (state_reg)
        PRS_RUN:
        begin
          if (instr_valid_i && instr_opcode_i == prs_pkg::OPC_STOP)
            state_reg <= PRS_STOP;
          else if (instr_valid_i && instr_opcode_i == prs_pkg::OPC_HALT)
            state_reg <= PRS_HALT;
        end
        PRS_HALT:
        begin
          if (irq_any_i)
            state_reg <= PRS_RUN; // RL10
        end
        PRS_STOP:
        begin
          if (stop_wake)
            state_reg <= PRS_RUN; // RL12
        end
        default:
          state_reg <= PRS_RUN;
      endcase
    end
  end
  assign stop_exit = (state_reg == PRS_STOP) && stop_wake && !wdog_fire; // RL12
  // Power-fail also holds the core, so it never runs before the delay has started
  assign core_hold = !power_ok_i || por_busy || por_start; // RL1
  // ----------------------------------------
  // Core-side outputs
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      resume_load_o <= 1'b0;
      resume_addr_o <= '0;
    end
    else
    begin
      resume_load_o <= stop_exit; // RL13
      if (stop_exit)
        resume_addr_o <= prs_pkg::STOP_RESUME_ADDR; // RL13
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      osc_enable_o <= 1'b1;
      timer_irq_en_o <= 1'b1;
    end
    else
    begin
      osc_enable_o <= (state_reg != PRS_STOP); // RL11
      timer_irq_en_o <= (state_reg != PRS_STOP); // RL9
    end
  end
  // Stop wake goes straight to run, no power-on wait
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      core_clk_en_o <= 1'b0;
    else
      core_clk_en_o <= (state_reg == PRS_RUN) && !core_hold; // RL1 RL3 RL9 RL11
  end
  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      wdog_halt_en_o <= prs_pkg::WDOG_HALT_RESET; // RL8
    else if (wdog_halt_wr_i)
      wdog_halt_en_o <= wdog_halt_data_i;
  end
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      wdog_running_o <= WDOG_AUTO_START; // RL5
    else if (wdog_enable_i)
      wdog_running_o <= 1'b1;
  end
  // Oscillator is off in stop, so the watchdog freezes there
  assign wdog_tick = wdog_running_o && (state_reg == PRS_RUN || (state_reg == PRS_HALT && wdog_halt_en_o)); // RL4 RL8
  assign wdog_fire = wdog_tick && (wdog_count_reg == '0) && !wdog_refresh_i;
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i || wdog_refresh_i || wdog_fire || !wdog_running_o)
      wdog_count_reg <= prs_pkg::WDOG_W'(WDOG_PERIOD - 1); // RL16
    else if (wdog_tick)
      wdog_count_reg <= wdog_count_reg - 1'b1; // RL4
  end
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      core_reset_n_o <= 1'b0;
    else
      core_reset_n_o <= !wdog_fire && !core_hold; // RL15 RL1
  end
  // ----------------------------------------
  // Start-type flag
  // ----------------------------------------
  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      warm_start_flag_o <= 1'b0; // RL6
    else if (wdog_fire)
      warm_start_flag_o <= 1'b1; // RL15 RL6
    else if (flag_access_i)
      warm_start_flag_o <= 1'b0; // RL7
  end
endmodule : prs_power_reset_sleep
`default_nettype wire
